// >>> rtl/aaim_core.sv
// Interrupt latching, masking, pulse generation and input monitor with AXI4-Lite registers
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

module aaim_core #(
   parameter int MS_CYCLES = aaim_pkg::MS_CYCLES
) (
   input wire logic clock,
   input wire logic resetn,
   input wire logic [aaim_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [aaim_pkg::DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [aaim_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [aaim_pkg::DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [aaim_pkg::NUM_EVENTS-1:0] event_pulses,
   input wire logic general_input_one,
   input wire logic mic_bias_pin,
   output logic irq_output
);

   localparam int DIV_W = $clog2(MS_CYCLES);
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(MS_CYCLES - 1);

   // Refuse a timebase too short to count
   if (MS_CYCLES < 2)
   begin : g_bad_ms
      $error("MS_CYCLES must be at least 2");
   end

   // Word index hit: aligned word of the given register index
   function automatic logic reg_hit(input logic [aaim_pkg::ADDR_W-1:0] addr, input logic [5:0] idx);
      reg_hit = (addr[aaim_pkg::ADDR_W-1:2] == idx);
   endfunction

   // Registers
   aaim_pkg::aaim_irq_cfg_t cfg_r;
   logic [7:0] mask_r;
   logic [7:0] latch_r;
   logic [7:0] func_r;
   logic [7:0] bias_r;
   logic [7:0] mon_r;
   logic aw_got_r;
   logic w_got_r;
   logic [aaim_pkg::ADDR_W-1:0] waddr_r;
   logic [7:0] wbyte_r;
   logic wlane_r;
   logic awready_r;
   logic wready_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic arready_r;
   logic rvalid_r;
   logic [aaim_pkg::DATA_W-1:0] rdata_r;
   logic [1:0] rresp_r;
   logic [DIV_W-1:0] div_r;
   logic [2:0] phase_r;
   logic [2:0] pulse_left_r;
   logic irq_r;

   // Bus handshakes
   wire logic aw_take = s_axi_awvalid & awready_r;
   wire logic w_take = s_axi_wvalid & wready_r;
   wire logic do_write = aw_got_r & w_got_r & ~bvalid_r;
   wire logic ar_take = s_axi_arvalid & arready_r;
   wire logic aw_got_nxt = do_write ? 1'b0 : (aw_got_r | aw_take);
   wire logic w_got_nxt = do_write ? 1'b0 : (w_got_r | w_take);

   // Write decode, low byte lane carries the register
   wire logic wr_en = do_write & wlane_r;
   wire logic wr_cfg = wr_en & reg_hit(waddr_r, aaim_pkg::IDX_INTERRUPT_CONFIG);
   wire logic wr_mask = wr_en & reg_hit(waddr_r, aaim_pkg::IDX_INTERRUPT_MASK_BANK);
   wire logic wr_func = wr_en & reg_hit(waddr_r, aaim_pkg::IDX_INPUT_FUNCTION);
   wire logic wr_bias = wr_en & reg_hit(waddr_r, aaim_pkg::IDX_BIAS_CONFIG);
   wire logic wr_mapped = reg_hit(waddr_r, aaim_pkg::IDX_INTERRUPT_CONFIG)
      | reg_hit(waddr_r, aaim_pkg::IDX_INTERRUPT_MASK_BANK)
      | reg_hit(waddr_r, aaim_pkg::IDX_INPUT_FUNCTION)
      | reg_hit(waddr_r, aaim_pkg::IDX_BIAS_CONFIG)
      | reg_hit(waddr_r, aaim_pkg::IDX_INTERRUPT_LATCH_BANK)
      | reg_hit(waddr_r, aaim_pkg::IDX_GENERAL_INPUT_LEVEL);

   // New configuration from the written byte
   wire aaim_pkg::aaim_irq_cfg_t cfg_wr = '{
      polarity: wbyte_r[aaim_pkg::POS_POLARITY],
      mode: wbyte_r[aaim_pkg::POS_MODE_LO +: 2],
      view: wbyte_r[aaim_pkg::POS_VIEW]
   };
   wire logic mode_chg = wr_cfg & (cfg_wr.mode != cfg_r.mode);

   // Events placed at their latch positions; view hides masked bits
   wire logic [7:0] ev8 = {event_pulses, 3'h0};
   wire logic [7:0] unmasked = ~mask_r & {{aaim_pkg::NUM_EVENTS{1'b1}}, 3'h0};
   wire logic [7:0] view_mask = cfg_r.view ? unmasked : {{aaim_pkg::NUM_EVENTS{1'b1}}, 3'h0};
   wire logic [7:0] latch_view = latch_r & view_mask;
   wire logic rd_latch = ar_take & reg_hit(s_axi_araddr, aaim_pkg::IDX_INTERRUPT_LATCH_BANK);
   wire logic [7:0] latch_nxt = ev8 | (latch_r & ~(rd_latch ? view_mask : 8'h00));

   // Read data selection
   wire logic rd_latch_addr = reg_hit(s_axi_araddr, aaim_pkg::IDX_INTERRUPT_LATCH_BANK);
   wire logic rd_mapped = reg_hit(s_axi_araddr, aaim_pkg::IDX_INTERRUPT_CONFIG)
      | reg_hit(s_axi_araddr, aaim_pkg::IDX_INTERRUPT_MASK_BANK)
      | reg_hit(s_axi_araddr, aaim_pkg::IDX_INPUT_FUNCTION)
      | reg_hit(s_axi_araddr, aaim_pkg::IDX_BIAS_CONFIG)
      | rd_latch_addr
      | reg_hit(s_axi_araddr, aaim_pkg::IDX_GENERAL_INPUT_LEVEL);
   wire logic [7:0] cfg_byte = {cfg_r.polarity, cfg_r.mode, 2'h0, cfg_r.view, 2'h0};
   wire logic [7:0] rd_byte =
      reg_hit(s_axi_araddr, aaim_pkg::IDX_INTERRUPT_CONFIG) ? cfg_byte :
      reg_hit(s_axi_araddr, aaim_pkg::IDX_INTERRUPT_MASK_BANK) ? mask_r :
      reg_hit(s_axi_araddr, aaim_pkg::IDX_INPUT_FUNCTION) ? func_r :
      reg_hit(s_axi_araddr, aaim_pkg::IDX_BIAS_CONFIG) ? bias_r :
      rd_latch_addr ? latch_view :
      reg_hit(s_axi_araddr, aaim_pkg::IDX_GENERAL_INPUT_LEVEL) ? mon_r : aaim_pkg::RST_ZERO;

   // Monitor levels, valid only in input function
   wire logic one_is_input = func_r[aaim_pkg::POS_FUNC_LO +: 3] == aaim_pkg::INPUT_ONE_GPI;
   wire logic two_is_input = bias_r[aaim_pkg::POS_FUNC_LO +: 3] == aaim_pkg::BIAS_AS_INPUT_TWO;
   wire logic [7:0] mon_nxt = {one_is_input & general_input_one, two_is_input & mic_bias_pin, 6'h00};

   // Interrupt source terms
   wire logic pending = |(latch_r & unmasked);
   wire logic trigger = |(ev8 & unmasked);
   wire logic ms_tick = (div_r == DIV_LAST);
   wire logic in_single = cfg_r.mode == aaim_pkg::MODE_SINGLE;
   wire logic in_periodic = cfg_r.mode == aaim_pkg::MODE_PERIODIC;
   wire logic div_restart = mode_chg | (in_single & trigger) | (in_periodic & ~pending);
   wire logic [DIV_W-1:0] div_nxt = (div_restart | ms_tick) ? '0 : div_r + 1'b1;
   wire logic [2:0] phase_wrap = (phase_r == aaim_pkg::PERIOD_TICKS - 3'h1) ? 3'h0 : phase_r + 3'h1;
   wire logic [2:0] phase_nxt = (mode_chg | ~pending) ? 3'h0 : (ms_tick ? phase_wrap : phase_r);
   wire logic [2:0] pulse_dec = (ms_tick && pulse_left_r != 3'h0) ? pulse_left_r - 3'h1 : pulse_left_r;
   wire logic [2:0] pulse_nxt = mode_chg ? 3'h0 : ((in_single & trigger) ? aaim_pkg::PULSE_TICKS : pulse_dec);

   // Active state per event mode
   logic irq_active;
   always_comb
   begin
      case (cfg_r.mode)
         aaim_pkg::MODE_LEVEL: irq_active = pending;
         aaim_pkg::MODE_PERIODIC: irq_active = pending & (phase_r < aaim_pkg::PULSE_TICKS);
         aaim_pkg::MODE_SINGLE: irq_active = trigger | (pulse_left_r != 3'h0);
         default: irq_active = 1'b0;
      endcase
   end
   wire logic irq_nxt = ~(irq_active ^ cfg_r.polarity);

   // Write channel acceptance and response
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         aw_got_r <= 1'b0;
         w_got_r <= 1'b0;
         awready_r <= 1'b1;
         wready_r <= 1'b1;
         bvalid_r <= 1'b0;
         bresp_r <= aaim_pkg::RESP_OKAY;
         waddr_r <= '0;
         wbyte_r <= aaim_pkg::RST_ZERO;
         wlane_r <= 1'b0;
      end
      else
      begin
         aw_got_r <= aw_got_nxt;
         w_got_r <= w_got_nxt;
         awready_r <= ~aw_got_nxt;
         wready_r <= ~w_got_nxt;
         if (aw_take)
            waddr_r <= s_axi_awaddr;
         if (w_take)
         begin
            wbyte_r <= s_axi_wdata[7:0];
            wlane_r <= s_axi_wstrb[0];
         end
         if (do_write)
         begin
            bvalid_r <= 1'b1;
            bresp_r <= wr_mapped ? aaim_pkg::RESP_OKAY : aaim_pkg::RESP_SLVERR;
         end
         else if (s_axi_bready)
            bvalid_r <= 1'b0;
      end
   end

   // Read channel
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         arready_r <= 1'b1;
         rvalid_r <= 1'b0;
         rdata_r <= '0;
         rresp_r <= aaim_pkg::RESP_OKAY;
      end
      else if (ar_take)
      begin
         arready_r <= 1'b0;
         rvalid_r <= 1'b1;
         rdata_r <= {24'h000000, rd_byte};
         rresp_r <= rd_mapped ? aaim_pkg::RESP_OKAY : aaim_pkg::RESP_SLVERR;
      end
      else if (rvalid_r & s_axi_rready)
      begin
         arready_r <= 1'b1;
         rvalid_r <= 1'b0;
      end
   end

   // Software registers; masks come up all set
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         cfg_r <= '0;
         mask_r <= aaim_pkg::RST_MASK;
         func_r <= aaim_pkg::RST_ZERO;
         bias_r <= aaim_pkg::RST_ZERO;
      end
      else
      begin
         if (wr_cfg)
            cfg_r <= cfg_wr;
         if (wr_mask)
            mask_r <= wbyte_r;
         if (wr_func)
            func_r <= wbyte_r & aaim_pkg::WR_FUNCTION;
         if (wr_bias)
            bias_r <= wbyte_r & aaim_pkg::WR_BIAS;
      end
   end

   // Event latches, monitor samples, timebase and output
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         latch_r <= aaim_pkg::RST_ZERO;
         mon_r <= aaim_pkg::RST_ZERO;
         div_r <= '0;
         phase_r <= 3'h0;
         pulse_left_r <= 3'h0;
         irq_r <= 1'b1;
      end
      else
      begin
         latch_r <= latch_nxt;
         mon_r <= mon_nxt;
         div_r <= div_nxt;
         phase_r <= phase_nxt;
         pulse_left_r <= pulse_nxt;
         irq_r <= irq_nxt;
      end
   end

   assign s_axi_awready = awready_r;
   assign s_axi_wready = wready_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;
   assign irq_output = irq_r;

   // Checks on monitor bits
   mon_one_a: assert property (@(posedge clock) disable iff (!resetn)
      one_is_input |=> mon_r[aaim_pkg::POS_INPUT_ONE] == $past(general_input_one))
      else $error("input one monitor wrong");
   mon_gate_a: assert property (@(posedge clock) disable iff (!resetn)
      !one_is_input |=> !mon_r[aaim_pkg::POS_INPUT_ONE])
      else $error("input one monitor not gated");
   mon_two_a: assert property (@(posedge clock) disable iff (!resetn)
      two_is_input |=> mon_r[aaim_pkg::POS_INPUT_TWO] == $past(mic_bias_pin))
      else $error("input two monitor wrong");

   // Checks on the interrupt output
   level_mode_a: assert property (@(posedge clock) disable iff (!resetn)
      (cfg_r.mode == aaim_pkg::MODE_LEVEL) |=> irq_r == ($past(pending) ~^ $past(cfg_r.polarity)))
      else $error("level mode output wrong");
   reserved_quiet_a: assert property (@(posedge clock) disable iff (!resetn)
      (cfg_r.mode == aaim_pkg::MODE_RESERVED) |=> irq_r == !$past(cfg_r.polarity))
      else $error("reserved mode output active");
   single_pulse_a: assert property (@(posedge clock) disable iff (!resetn)
      (in_single && trigger && !wr_cfg) |=> irq_r == $past(cfg_r.polarity) ##0 pulse_left_r == 3'h2)
      else $error("single pulse not started");
   periodic_on_a: assert property (@(posedge clock) disable iff (!resetn)
      (in_periodic && pending && phase_r == 3'h0) |=> irq_r == $past(cfg_r.polarity))
      else $error("periodic pulse missing");
   periodic_off_a: assert property (@(posedge clock) disable iff (!resetn)
      (in_periodic && phase_r >= 3'h2) |=> irq_r == !$past(cfg_r.polarity))
      else $error("periodic pulse too long");

   // Checks on latches, timebase and mask reset value
   latch_set_a: assert property (@(posedge clock) disable iff (!resetn)
      (ev8 != 8'h00) |=> (latch_r & $past(ev8)) == $past(ev8))
      else $error("event not latched");
   read_clear_a: assert property (@(posedge clock) disable iff (!resetn)
      (rd_latch && ev8 == 8'h00) |=> (latch_r & $past(view_mask)) == 8'h00)
      else $error("latch read did not clear");
   latch_view_a: assert property (@(posedge clock) disable iff (!resetn)
      rd_latch |=> rdata_r[7:0] == ($past(latch_r) & $past(view_mask)) && rvalid_r)
      else $error("latch readback wrong");
   reserved_zero_a: assert property (@(posedge clock) disable iff (!resetn)
      latch_r[2:0] == 3'h0)
      else $error("reserved latch bits set");
   restart_tb_a: assert property (@(posedge clock) disable iff (!resetn)
      mode_chg |=> div_r == '0 && phase_r == 3'h0 && pulse_left_r == 3'h0)
      else $error("timebase not restarted");
   mask_reset_a: assert property (@(posedge clock)
      $rose(resetn) |-> mask_r == aaim_pkg::RST_MASK)
      else $error("mask reset value wrong");

   // Checks on register updates, counters and held or idle output
   cfg_write_a: assert property (@(posedge clock) disable iff (!resetn)
      wr_cfg |=> cfg_r == $past(cfg_wr))
      else $error("config write not stored");
   mask_write_a: assert property (@(posedge clock) disable iff (!resetn)
      wr_mask |=> mask_r == $past(wbyte_r))
      else $error("mask write not stored");
   latch_hold_a: assert property (@(posedge clock) disable iff (!resetn)
      (!rd_latch && ev8 == 8'h00) |=> latch_r == $past(latch_r))
      else $error("latch changed without read");
   mon_reserved_a: assert property (@(posedge clock) disable iff (!resetn)
      mon_r[5:0] == 6'h00)
      else $error("reserved monitor bits set");
   phase_bound_a: assert property (@(posedge clock) disable iff (!resetn)
      phase_r < aaim_pkg::PERIOD_TICKS)
      else $error("period phase out of range");
   pulse_bound_a: assert property (@(posedge clock) disable iff (!resetn)
      pulse_left_r <= aaim_pkg::PULSE_TICKS)
      else $error("pulse count out of range");
   single_hold_a: assert property (@(posedge clock) disable iff (!resetn)
      (in_single && pulse_left_r != 3'h0) |=> irq_r == $past(cfg_r.polarity))
      else $error("single pulse cut short");
   single_idle_a: assert property (@(posedge clock) disable iff (!resetn)
      (in_single && !trigger && pulse_left_r == 3'h0) |=> irq_r == !$past(cfg_r.polarity))
      else $error("single pulse too long");
   periodic_idle_a: assert property (@(posedge clock) disable iff (!resetn)
      (in_periodic && !pending) |=> irq_r == !$past(cfg_r.polarity))
      else $error("periodic output without pending");

endmodule

`default_nettype wire

// >>> rtl/aaim_pkg.sv
// Constants, register map and carrier types of the audio interrupt and input monitor block
package aaim_pkg;

   // Register bus geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int REG_W = 8;
   localparam int NUM_EVENTS = 5;

   // Register indices; byte address is four times the index
   localparam logic [5:0] IDX_GENERAL_INPUT_LEVEL = 6'h2F;
   localparam logic [5:0] IDX_INPUT_FUNCTION = 6'h2B;
   localparam logic [5:0] IDX_INTERRUPT_CONFIG = 6'h32;
   localparam logic [5:0] IDX_INTERRUPT_MASK_BANK = 6'h33;
   localparam logic [5:0] IDX_INTERRUPT_LATCH_BANK = 6'h36;
   localparam logic [5:0] IDX_BIAS_CONFIG = 6'h3B;

   // Field positions
   localparam int POS_INPUT_ONE = 7;
   localparam int POS_INPUT_TWO = 6;
   localparam int POS_POLARITY = 7;
   localparam int POS_MODE_LO = 5;
   localparam int POS_VIEW = 2;
   localparam int POS_FUNC_LO = 4;
   localparam int POS_EVENT_LO = 3;
   localparam int POS_ADC_SCALE_LO = 0;

   // Field codes
   localparam logic [2:0] INPUT_ONE_GPI = 3'h1;
   localparam logic [2:0] BIAS_AS_INPUT_TWO = 3'h7;
   localparam logic [1:0] MODE_LEVEL = 2'h0;
   localparam logic [1:0] MODE_RESERVED = 2'h1;
   localparam logic [1:0] MODE_PERIODIC = 2'h2;
   localparam logic [1:0] MODE_SINGLE = 2'h3;

   // Reset values and writable bit masks
   localparam logic [7:0] RST_MASK = 8'hFF;
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] WR_FUNCTION = 8'h77;
   localparam logic [7:0] WR_BIAS = 8'h73;

   // Bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Timing: clock period and pulse figures in their own units
   localparam int CLK_PERIOD_NS = 25;
   localparam int MS_TIME_NS = 1000000;
   localparam int MS_CYCLES = MS_TIME_NS / CLK_PERIOD_NS;
   localparam int PULSE_TIME_MS = 2;
   localparam int PERIOD_TIME_MS = 4;
   localparam logic [2:0] PULSE_TICKS = 3'(PULSE_TIME_MS);
   localparam logic [2:0] PERIOD_TICKS = 3'(PERIOD_TIME_MS);

   // Interrupt configuration fields
   typedef struct packed {
      logic polarity;
      logic [1:0] mode;
      logic view;
   } aaim_irq_cfg_t;

endpackage

// >>> bench/aaim_host_model.sv
// Host processor model: AXI4-Lite master with register write and read tasks
`timescale 1ns/1ps
`default_nettype none

module aaim_host_model (
   input wire logic clock,
   output logic [7:0] awaddr,
   output logic awvalid,
   input wire logic awready,
   output logic [31:0] wdata,
   output logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   output logic bready,
   output logic [7:0] araddr,
   output logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   output logic rready
);
   // Idle bus from time zero
   initial
   begin
      awaddr = 8'h00;
      awvalid = 1'b0;
      wdata = 32'h00000000;
      wvalid = 1'b0;
      bready = 1'b0;
      araddr = 8'h00;
      arvalid = 1'b0;
      rready = 1'b0;
   end

   // Write: address and data together, each released when taken, slow or prompt response accept
   task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
      logic aw;
      logic w;
      @(posedge clock);
      awaddr <= a;
      wdata <= {24'h000000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      aw = 1'b1;
      w = 1'b1;
      while (aw || w)
      begin
         @(posedge clock);
         if (aw && awready)
         begin
            aw = 1'b0;
            awvalid <= 1'b0;
            awaddr <= ~a;
         end
         if (w && wready)
         begin
            w = 1'b0;
            wvalid <= 1'b0;
            wdata <= ~wdata;
         end
      end
      repeat ($urandom_range(2)) @(posedge clock);
      bready <= 1'b1;
      do
         @(posedge clock);
      while (!bvalid);
      r = bresp;
      bready <= 1'b0;
   endtask

   // Read: address held until taken, data taken at the rvalid edge
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clock);
      araddr <= a;
      arvalid <= 1'b1;
      do
         @(posedge clock);
      while (!arready);
      arvalid <= 1'b0;
      araddr <= ~a;
      repeat ($urandom_range(2)) @(posedge clock);
      rready <= 1'b1;
      do
         @(posedge clock);
      while (!rvalid);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
endmodule

`default_nettype wire

// >>> bench/tb.sv
// Self-checking testbench of the interrupt and input monitor block
`timescale 1ns/1ps
`default_nettype none

module tb;
   localparam int MS = 8;
   localparam logic [7:0] A_MON = {aaim_pkg::IDX_GENERAL_INPUT_LEVEL, 2'b00};
   localparam logic [7:0] A_FUNC = {aaim_pkg::IDX_INPUT_FUNCTION, 2'b00};
   localparam logic [7:0] A_CFG = {aaim_pkg::IDX_INTERRUPT_CONFIG, 2'b00};
   localparam logic [7:0] A_MASK = {aaim_pkg::IDX_INTERRUPT_MASK_BANK, 2'b00};
   localparam logic [7:0] A_LATCH = {aaim_pkg::IDX_INTERRUPT_LATCH_BANK, 2'b00};
   localparam logic [7:0] A_BIAS = {aaim_pkg::IDX_BIAS_CONFIG, 2'b00};
   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic [4:0] ev = 5'h00;
   logic pin1 = 1'b0;
   logic pin2 = 1'b0;
   logic irq_output;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, d;
   logic [1:0] bresp, rresp, r;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   int failures = 0;
   int n_compared = 0;
   int cycles = 0;
   int i;
   int j;
   int c;

   // 40 MHz clock
   always #12.5 clock = ~clock;

   aaim_core #(.MS_CYCLES(MS)) aaim_core_i (.clock(clock), .resetn(resetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .event_pulses(ev), .general_input_one(pin1), .mic_bias_pin(pin2), .irq_output(irq_output));

   aaim_host_model aaim_host_model_i (.clock(clock), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

   // Verdict and end of run
   task automatic complete_run();
      if (failures == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // Hang guard
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         failures++;
         complete_run();
      end
   end

   // Compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Expected pin level for an active or idle line under a polarity
   function automatic logic lvl(input logic active, input logic pol);
      return active ~^ pol;
   endfunction

   // Expected latch bit of an event source
   function automatic logic [31:0] lbit(input int k);
      return 32'h08 << k;
   endfunction

   // Register read with expected data and okay response
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      aaim_host_model_i.rd(a, d, r);
      chk(d, exp);
      chk(32'(r), 32'(aaim_pkg::RESP_OKAY));
   endtask

   // One-cycle event pulse on a source
   task automatic fire(input int k);
      @(posedge clock);
      ev <= 5'h01 << k;
      @(posedge clock);
      ev <= 5'h00;
   endtask

   // Count active-high interrupt cycles
   task automatic count_active(input int n);
      c = 0;
      repeat (n)
      begin
         @(posedge clock);
         if (irq_output === 1'b1)
            c++;
      end
   endtask

   // Main sequence
   initial
   begin
      void'($urandom(32'hCF4598DA));
      repeat (20) @(posedge clock);
      resetn <= 1'b1;
      @(posedge clock);
      chk(32'(irq_output), 32'(lvl(1'b0, 1'b0)));
      rd_chk(A_CFG, 32'h00);
      rd_chk(A_MASK, 32'hFF);
      rd_chk(A_LATCH, 32'h00);
      aaim_host_model_i.wr(A_MON, 8'hFF, r);
      chk(32'(r), 32'(aaim_pkg::RESP_OKAY));
      rd_chk(A_MON, 32'h00);
      aaim_host_model_i.rd(8'h04, d, r);
      chk(32'(r), 32'(aaim_pkg::RESP_SLVERR));
      chk(d, 32'h00000000);
      // Monitored pins with both functions selected
      aaim_host_model_i.wr(A_FUNC, 8'h10, r);
      aaim_host_model_i.wr(A_BIAS, 8'h70, r);
      repeat (4)
      begin
         pin1 <= 1'($urandom);
         pin2 <= 1'($urandom);
         @(posedge clock);
         rd_chk(A_MON, {24'h0, pin1, pin2, 6'h00});
      end
      pin1 <= 1'b1;
      pin2 <= 1'b1;
      aaim_host_model_i.wr(A_FUNC, 8'h20, r);
      aaim_host_model_i.wr(A_BIAS, 8'h60, r);
      rd_chk(A_MON, 32'h00);
      // Every source latches while masked, clears on read
      for (i = 0; i < 5; i++)
      begin
         fire(i);
         rd_chk(A_LATCH, lbit(i));
         rd_chk(A_LATCH, 32'h00);
         chk(32'(irq_output), 32'(lvl(1'b0, 1'b0)));
      end
      // One source unmasked, level mode, masked-view readback
      i = $urandom_range(4);
      j = (i + 1) % 5;
      aaim_host_model_i.wr(A_MASK, 8'(~lbit(i)), r);
      aaim_host_model_i.wr(A_CFG, 8'h04, r);
      fire(j);
      repeat (2) @(posedge clock);
      chk(32'(irq_output), 32'(lvl(1'b0, 1'b0)));
      rd_chk(A_LATCH, 32'h00);
      fire(i);
      repeat (2) @(posedge clock);
      chk(32'(irq_output), 32'(lvl(1'b1, 1'b0)));
      aaim_host_model_i.wr(A_CFG, 8'h84, r);
      repeat (2) @(posedge clock);
      chk(32'(irq_output), 32'(lvl(1'b1, 1'b1)));
      rd_chk(A_LATCH, lbit(i));
      repeat (2) @(posedge clock);
      chk(32'(irq_output), 32'(lvl(1'b0, 1'b1)));
      aaim_host_model_i.wr(A_CFG, 8'h80, r);
      rd_chk(A_LATCH, lbit(j));
      // Periodic mode: half of each 4 ms period while pending
      aaim_host_model_i.wr(A_CFG, 8'hC0, r);
      fire(i);
      count_active(8 * MS);
      chk(32'(c >= 4 * MS - 2 && c <= 4 * MS + 2), 32'h1);
      rd_chk(A_LATCH, lbit(i));
      // Reserved mode keeps the line idle although an event is pending
      aaim_host_model_i.wr(A_CFG, 8'hA0, r);
      fire(i);
      repeat (2) @(posedge clock);
      chk(32'(irq_output), 32'(lvl(1'b0, 1'b1)));
      // Single-pulse mode: one 2 ms pulse, latch still pending afterwards
      aaim_host_model_i.wr(A_CFG, 8'hE0, r);
      fire(i);
      count_active(5 * MS);
      chk(32'(c >= MS && c <= 2 * MS + 2), 32'h1);
      chk(32'(irq_output), 32'(lvl(1'b0, 1'b1)));
      rd_chk(A_LATCH, lbit(i));
      fire(j);
      count_active(5 * MS);
      chk(32'(c), 32'h0);
      rd_chk(A_LATCH, lbit(j));
      complete_run();
   end
endmodule

`default_nettype wire
